// ==== logic/pefc_filter.sv ====
// Threshold, complement and rising-edge filter for one counter's four event lines.
// Assumes lines and run come from logic on sys_clk.
`timescale 1ns/1ps
module pefc_filter (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      run,
  input  wire logic [3:0]                lines,
  input  wire pefc_pkg::pefc_filter_cfg_t cfg,
  output logic      [3:0]                incr
);

  logic thr_hit;
  logic hist_q;

  // Lines are weighted 1, 2, 4, 8, so the vector itself is the value.
  always_comb begin
    if (cfg.complement) begin
      thr_hit = (lines <= cfg.threshold); // RULE8 RULE9
    end else begin
      thr_hit = (lines > cfg.threshold); // RULE8 RULE9
    end
  end

  // History is cleared while stopped so a restart cannot see a stale high.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !run) begin
      hist_q <= 1'b0; // RULE17
    end else begin
      hist_q <= thr_hit; // RULE12
    end
  end

  always_comb begin
    if (!cfg.compare) begin
      incr = lines; // RULE5 RULE6 RULE11
    end else if (cfg.edge_en) begin
      incr = {3'h0, thr_hit & ~hist_q}; // RULE12
    end else begin
      incr = {3'h0, thr_hit}; // RULE7 RULE10
    end
  end

endmodule : pefc_filter

// ==== logic/pefc_pkg.sv ====
// Constants, field layouts and carrier types of the event filter counter.
// Assumes a 32-bit register bus with byte addressing and word-aligned registers.
package pefc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_EVENT_SELECTION_REGISTER_BASE  = 8'h00;
  localparam logic [7:0] OFS_CCCR0      = 8'h20;
  localparam logic [7:0] OFS_CNT0_LO    = 8'h24;
  localparam logic [7:0] OFS_CNT0_HI    = 8'h28;
  localparam logic [7:0] OFS_CCCR1      = 8'h30;
  localparam logic [7:0] OFS_CNT1_LO    = 8'h34;
  localparam logic [7:0] OFS_CNT1_HI    = 8'h38;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h44;

  // ----------------------------------------------------------------------
  // Event selection register fields
  // ----------------------------------------------------------------------
  localparam int EVENT_SELECTION_REGISTER_SEL_LSB  = 25;
  localparam int EVENT_SELECTION_REGISTER_SEL_W    = 7;
  localparam int EVENT_SELECTION_REGISTER_MASK_LSB = 9;
  localparam int EVENT_SELECTION_REGISTER_MASK_W   = 16;
  localparam int EVENT_SELECTION_REGISTER_OS_BIT   = 3;
  localparam int EVENT_SELECTION_REGISTER_USR_BIT  = 2;

  // ----------------------------------------------------------------------
  // Counter configuration register fields
  // ----------------------------------------------------------------------
  localparam int COUNTER_CONFIGURATION_REGISTER_EN_BIT   = 12;
  localparam int COUNTER_CONFIGURATION_REGISTER_SEL_LSB  = 13;
  localparam int COUNTER_CONFIGURATION_REGISTER_SEL_W    = 3;
  localparam int COUNTER_CONFIGURATION_REGISTER_CMP_BIT  = 18;
  localparam int COUNTER_CONFIGURATION_REGISTER_CMPL_BIT = 19;
  localparam int COUNTER_CONFIGURATION_REGISTER_THR_LSB  = 20;
  localparam int COUNTER_CONFIGURATION_REGISTER_THR_W    = 4;
  localparam int COUNTER_CONFIGURATION_REGISTER_EDGE_BIT = 24;
  localparam int COUNTER_CONFIGURATION_REGISTER_CASC_BIT = 30;
  localparam int COUNTER_CONFIGURATION_REGISTER_OVF_BIT  = 31;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] EVENT_SELECTION_REGISTER_RST  = 32'h0000_0000;
  localparam logic [31:0] COUNTER_CONFIGURATION_REGISTER_RST  = 32'h0000_0000;
  localparam logic [63:0] COUNT_RST = 64'h0000_0000_0000_0000;
  localparam logic [1:0]  IRQ_RST   = 2'h0;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       compare;
    logic       complement;
    logic [3:0] threshold;
    logic       edge_en;
  } pefc_filter_cfg_t;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pefc_bus_req_t;

endpackage : pefc_pkg

// ==== logic/pefc_top.sv ====
// Event filter counter pair with event selection registers and an Avalon-MM slave.
// Assumes event lines and privilege level come from logic on sys_clk.
//
// How it works
// RULE1 - Event mask field starts at bit nine.
// RULE2 - Software writes zero to undefined mask bits.
// RULE3 - Configuration selector holds selection register index.
// RULE4 - Separate user and supervisor qualify flags.
// RULE5 - Four event lines weighted 1, 2, 4, 8.
// RULE6 - Unfiltered counting adds weighted sum each cycle.
// RULE7 - Compare flag switches to threshold comparison.
// RULE8 - Complement picks less-or-equal versus greater.
// RULE9 - Threshold is a four-bit operand.
// RULE10 - Threshold hit adds exactly one.
// RULE11 - Edge flag only works with compare.
// RULE12 - Edge filter counts false-to-true transitions only.
// RULE13 - Enable flag starts counting until cleared.
// RULE14 - Overflow starts the cascaded partner counter.
// RULE15 - Counter wraps and sets sticky overflow flag.
// RULE16 - Arm cascade with cascade set, enable clear.
// RULE17 - Stopped counter holds value, clears edge history.
// RULE18 - Software count write beats increment.
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module pefc_top #(
  parameter int CNT_W    = 40,
  parameter int NUM_EVENT_SELECTION_REGISTER = 8
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic [NUM_EVENT_SELECTION_REGISTER-1:0][3:0]  evt_lines,
  input  wire logic                      user_mode,
  output logic                           irq
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (CNT_W < 33 || CNT_W > 64) begin : g_bad_cnt_w
    $error("CNT_W must lie between 33 and 64.");
  end
  if (NUM_EVENT_SELECTION_REGISTER < 1 || NUM_EVENT_SELECTION_REGISTER > 8) begin : g_bad_event_selection_register
    $error("NUM_EVENT_SELECTION_REGISTER must lie between 1 and 8.");
  end

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  // Every access takes one wait state: the first edge latches read data,
  // the second edge completes the transfer.
  pefc_pkg::pefc_bus_req_t req;
  logic                    wait_q;
  logic                    acc;
  logic                    wr_en;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};
  assign acc = (req.read || req.write) && !wait_q;
  assign wr_en = req.write && !wait_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (req.read || req.write) begin
      wait_q <= 1'b0;
    end
  end

  assign avs_waitrequest = wait_q;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [31:0]      event_selection_register_q [NUM_EVENT_SELECTION_REGISTER];
  logic [31:0]      counter_configuration_register_q [2];
  logic [CNT_W-1:0] count_q [2];
  logic [1:0]       irq_status_q;
  logic [1:0]       irq_mask_q;
  logic             irq_q;

  logic [7:0] ofs_counter_configuration_register   [2];
  logic [7:0] ofs_cnt_lo [2];
  logic [7:0] ofs_cnt_hi [2];
  assign ofs_counter_configuration_register[0]   = pefc_pkg::OFS_CCCR0;
  assign ofs_counter_configuration_register[1]   = pefc_pkg::OFS_CCCR1;
  assign ofs_cnt_lo[0] = pefc_pkg::OFS_CNT0_LO;
  assign ofs_cnt_lo[1] = pefc_pkg::OFS_CNT1_LO;
  assign ofs_cnt_hi[0] = pefc_pkg::OFS_CNT0_HI;
  assign ofs_cnt_hi[1] = pefc_pkg::OFS_CNT1_HI;

  logic [7:0] addr_w;
  assign addr_w = {req.address[7:2], 2'h0};

  // ----------------------------------------------------------------------
  // Event selection registers
  // ----------------------------------------------------------------------
  // Mask bits are stored as written; undefined subevent bits are expected
  // to be written as zero and are not policed here.
  always_ff @(posedge sys_clk) begin
    for (int e = 0; e < NUM_EVENT_SELECTION_REGISTER; e++) begin
      if (!rst_n) begin
        event_selection_register_q[e] <= pefc_pkg::EVENT_SELECTION_REGISTER_RST;
      end else if (wr_en && addr_w == pefc_pkg::OFS_EVENT_SELECTION_REGISTER_BASE + 8'(4 * e)) begin
        event_selection_register_q[e] <= merge(event_selection_register_q[e], req.writedata, req.byteenable); // RULE1 RULE2 RULE4
      end
    end
  end

  // ----------------------------------------------------------------------
  // Counter channels
  // ----------------------------------------------------------------------
  logic [1:0]       run;
  logic [1:0]       ovf_evt;
  logic [3:0]       incr [2];
  logic [CNT_W:0]   sum  [2];
  logic [63:0]      cnt_ext [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [pefc_pkg::COUNTER_CONFIGURATION_REGISTER_SEL_W-1:0] sel;
    logic [31:0]                     event_selection_register;
    logic                            qualify;
    logic [3:0]                      lines;
    pefc_pkg::pefc_filter_cfg_t      cfg;

    assign sel = counter_configuration_register_q[c][pefc_pkg::COUNTER_CONFIGURATION_REGISTER_SEL_LSB +: pefc_pkg::COUNTER_CONFIGURATION_REGISTER_SEL_W]; // RULE3
    assign event_selection_register = (int'(sel) < NUM_EVENT_SELECTION_REGISTER) ? event_selection_register_q[int'(sel)] : 32'h0000_0000; // RULE3
    assign qualify = user_mode ? event_selection_register[pefc_pkg::EVENT_SELECTION_REGISTER_USR_BIT]
                               : event_selection_register[pefc_pkg::EVENT_SELECTION_REGISTER_OS_BIT]; // RULE4
    assign lines = qualify ? evt_lines[int'(sel) % NUM_EVENT_SELECTION_REGISTER] : 4'h0;

    assign cfg = '{compare:    counter_configuration_register_q[c][pefc_pkg::COUNTER_CONFIGURATION_REGISTER_CMP_BIT],
                   complement: counter_configuration_register_q[c][pefc_pkg::COUNTER_CONFIGURATION_REGISTER_CMPL_BIT],
                   threshold:  counter_configuration_register_q[c][pefc_pkg::COUNTER_CONFIGURATION_REGISTER_THR_LSB +: pefc_pkg::COUNTER_CONFIGURATION_REGISTER_THR_W],
                   edge_en:    counter_configuration_register_q[c][pefc_pkg::COUNTER_CONFIGURATION_REGISTER_EDGE_BIT]};

    // Cascade start holds only while the partner's sticky overflow stays set,
    // so clearing either that flag or the cascade flag halts the counter.
    assign run[c] = counter_configuration_register_q[c][pefc_pkg::COUNTER_CONFIGURATION_REGISTER_EN_BIT] // RULE13
                  | (counter_configuration_register_q[c][pefc_pkg::COUNTER_CONFIGURATION_REGISTER_CASC_BIT]
                     & counter_configuration_register_q[1-c][pefc_pkg::COUNTER_CONFIGURATION_REGISTER_OVF_BIT]); // RULE14 RULE16

    pefc_filter u_filter (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .run     (run[c]),
      .lines   (lines),
      .cfg     (cfg),
      .incr    (incr[c])
    );

    assign sum[c] = {1'b0, count_q[c]} + (CNT_W + 1)'(incr[c]); // RULE6
    assign ovf_evt[c] = run[c] && sum[c][CNT_W]; // RULE15
    assign cnt_ext[c] = 64'(count_q[c]);
  end

  // ----------------------------------------------------------------------
  // Configuration registers and counts
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (!rst_n) begin
        counter_configuration_register_q[c] <= pefc_pkg::COUNTER_CONFIGURATION_REGISTER_RST;
      end else begin
        if (wr_en && addr_w == ofs_counter_configuration_register[c]) begin
          counter_configuration_register_q[c] <= merge(counter_configuration_register_q[c], req.writedata, req.byteenable);
        end
        // A new overflow wins over a software clear in the same cycle.
        if (ovf_evt[c]) begin
          counter_configuration_register_q[c][pefc_pkg::COUNTER_CONFIGURATION_REGISTER_OVF_BIT] <= 1'b1; // RULE15
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (!rst_n) begin
        count_q[c] <= CNT_W'(pefc_pkg::COUNT_RST);
      end else if (wr_en && addr_w == ofs_cnt_lo[c]) begin
        count_q[c] <= CNT_W'({cnt_ext[c][63:32],
                              merge(cnt_ext[c][31:0], req.writedata, req.byteenable)}); // RULE18
      end else if (wr_en && addr_w == ofs_cnt_hi[c]) begin
        count_q[c] <= CNT_W'({merge(cnt_ext[c][63:32], req.writedata, req.byteenable),
                              cnt_ext[c][31:0]}); // RULE18
      end else if (run[c]) begin
        count_q[c] <= sum[c][CNT_W-1:0]; // RULE6 RULE15
      end
      // Otherwise the count holds its value while stopped. RULE17
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_status_q <= pefc_pkg::IRQ_RST;
    end else if (wr_en && addr_w == pefc_pkg::OFS_IRQ_STATUS && req.byteenable[0]) begin
      irq_status_q <= (irq_status_q & ~req.writedata[1:0]) | ovf_evt;
    end else begin
      irq_status_q <= irq_status_q | ovf_evt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_mask_q <= pefc_pkg::IRQ_RST;
    end else if (wr_en && addr_w == pefc_pkg::OFS_IRQ_MASK && req.byteenable[0]) begin
      irq_mask_q <= req.writedata[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] rd_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int e = 0; e < NUM_EVENT_SELECTION_REGISTER; e++) begin
      if (addr_w == pefc_pkg::OFS_EVENT_SELECTION_REGISTER_BASE + 8'(4 * e)) begin
        rd_mux = event_selection_register_q[e];
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (addr_w == ofs_counter_configuration_register[c]) begin
        rd_mux = counter_configuration_register_q[c];
      end
      if (addr_w == ofs_cnt_lo[c]) begin
        rd_mux = cnt_ext[c][31:0];
      end
      if (addr_w == ofs_cnt_hi[c]) begin
        rd_mux = cnt_ext[c][63:32];
      end
    end
    if (addr_w == pefc_pkg::OFS_IRQ_STATUS) begin
      rd_mux = {30'h0000_0000, irq_status_q};
    end
    if (addr_w == pefc_pkg::OFS_IRQ_MASK) begin
      rd_mux = {30'h0000_0000, irq_mask_q};
    end
  end

  // Data is latched on the first edge of the request and stands through
  // the edge where waitrequest is seen low.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_q <= 32'h0000_0000;
    end else if (req.read && wait_q) begin
      rd_q <= rd_mux;
    end
  end

  assign avs_readdata = rd_q;

  logic unused_acc;
  assign unused_acc = acc;

endmodule : pefc_top

// ==== test/pefc_event_src.sv ====
// Model of the event sources that feed every selection register of pefc_top.
// Assumes sys_clk of the block; lines change just after a rising edge.
`timescale 1ns/1ps
module pefc_event_src #(
  parameter int NUM_EVENT_SELECTION_REGISTER = 2
) (
  input  wire logic                     sys_clk,
  output logic      [NUM_EVENT_SELECTION_REGISTER-1:0][3:0] evt_lines,
  output logic                          user_mode
);
  initial begin
    evt_lines = '0;
    user_mode = 1'b0;
  end

  // Every lane sees the same value, so both counters of the pair share a stream.
  task automatic drive(input logic [3:0] v);
    @(posedge sys_clk);
    evt_lines <= {NUM_EVENT_SELECTION_REGISTER{v}};
  endtask : drive

  task automatic set_user(input logic u);
    @(posedge sys_clk);
    user_mode <= u;
  endtask : set_user
endmodule : pefc_event_src

// ==== test/pefc_top_asserts.sv ====
// Port-level assertions for pefc_top.
// Assumes one clock domain and a master that keeps the Avalon-MM rules.
`timescale 1ns/1ps
module pefc_top_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----
  // Bus handshake
  // ----
  a_wait_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_has_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest low without a request");
  a_idle_wait_high: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_rd_data_stands: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[7:2] > 6'h11
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_state: assert property ($rose(rst_n) |-> avs_waitrequest && !irq && avs_readdata == 32'h0)
    else $error("outputs not at reset state");

  // ----
  // Interrupt
  // ----
  a_masked_no_irq: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
    && avs_address == pefc_pkg::OFS_IRQ_MASK && avs_writedata[1:0] == 2'h0 |=> ##1 !irq)
    else $error("irq high with all sources masked");
  a_irq_sticky_hold: assert property (irq && !avs_write && !$past(avs_write) |=> irq)
    else $error("irq dropped without a register write");
endmodule : pefc_top_asserts

// ==== test/pefc_top_bench.sv ====
// Self-checking bench for pefc_top: Avalon-MM tasks plus an event source model.
// Assumes pefc_pkg, pefc_top, pefc_event_src and pefc_top_asserts are compiled first.
`timescale 1ns/1ps
module pefc_top_bench;
  logic                  sys_clk         = 1'b0;
  logic                  rst_n           = 1'b0;
  logic       [7:0]      avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic       [31:0]     avs_writedata;
  logic       [3:0]      avs_byteenable;
  logic       [31:0]     avs_readdata;
  logic                  avs_waitrequest;
  logic                  irq;
  logic                  user_mode;
  logic       [1:0][3:0] evt_lines;
  logic       [31:0]     rd;
  logic       [3:0]      quiet;
  int                    n_errors        = 0;
  int                    compares        = 0;
  logic       [3:0]      pat [6]         = '{4'h6, 4'h7, 4'h7, 4'h0, 4'hf, 4'h2};
  pefc_pkg::pefc_filter_cfg_t modes [7]  = '{7'h00, 7'h4c, 7'h60, 7'h5e, 7'h4d, 7'h0d, 7'h7c};

  always #5 sys_clk = ~sys_clk;

  pefc_top #(.CNT_W(40), .NUM_EVENT_SELECTION_REGISTER(2)) dut_u (.sys_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .evt_lines, .user_mode, .irq);
  pefc_event_src #(.NUM_EVENT_SELECTION_REGISTER(2)) src_u (.sys_clk, .evt_lines, .user_mode);

  // ----
  // Tasks
  // ----
  task automatic complete_run();
    $display("mismatches %0d of %0d compares", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The request is held until waitrequest is sampled low; only the watchdog ends a stuck wait.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdc

  // Quiet cycles around the pattern carry a level that never passes the filter,
  // so the total does not depend on how many of them the counter sees.
  task automatic play(input logic [3:0] q);
    foreach (pat[i]) src_u.drive(pat[i]);
    src_u.drive(q);
    repeat (4) @(posedge sys_clk);
  endtask : play

  function automatic logic [31:0] counter_configuration_register(input logic en, input logic [2:0] sel,
                                       input pefc_pkg::pefc_filter_cfg_t f, input logic casc);
    counter_configuration_register = 32'h0;
    counter_configuration_register[pefc_pkg::COUNTER_CONFIGURATION_REGISTER_EN_BIT] = en;
    counter_configuration_register[pefc_pkg::COUNTER_CONFIGURATION_REGISTER_SEL_LSB +: 3] = sel;
    counter_configuration_register[pefc_pkg::COUNTER_CONFIGURATION_REGISTER_CMP_BIT] = f.compare;
    counter_configuration_register[pefc_pkg::COUNTER_CONFIGURATION_REGISTER_CMPL_BIT] = f.complement;
    counter_configuration_register[pefc_pkg::COUNTER_CONFIGURATION_REGISTER_THR_LSB +: 4] = f.threshold;
    counter_configuration_register[pefc_pkg::COUNTER_CONFIGURATION_REGISTER_EDGE_BIT] = f.edge_en;
    counter_configuration_register[pefc_pkg::COUNTER_CONFIGURATION_REGISTER_CASC_BIT] = casc;
  endfunction : counter_configuration_register

  function automatic logic [31:0] expect_cnt(input pefc_pkg::pefc_filter_cfg_t f);
    logic hit;
    logic last;
    expect_cnt = 32'h0;
    last = 1'b0;
    foreach (pat[i]) begin
      hit = f.complement ? (pat[i] <= f.threshold) : (pat[i] > f.threshold);
      if (!f.compare) expect_cnt += 32'(pat[i]);
      else expect_cnt += 32'(f.edge_en ? (hit && !last) : hit);
      last = hit;
    end
  endfunction : expect_cnt

  // ----
  // Sequence
  // ----
  initial begin
    avs_address <= 8'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0;
    avs_byteenable <= 4'hf;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc("cccr0 reset", pefc_pkg::OFS_CCCR0, 32'h0);
    rdc("status reset", pefc_pkg::OFS_IRQ_STATUS, 32'h0);
    bus(1'b1, 8'h4c, 32'hffff_ffff);
    rdc("unmapped", 8'h4c, 32'h0);
    bus(1'b1, pefc_pkg::OFS_EVENT_SELECTION_REGISTER_BASE, 32'h0200_020c);
    bus(1'b1, 8'h04, 32'h0200_020c);
    rdc("escr0", pefc_pkg::OFS_EVENT_SELECTION_REGISTER_BASE, 32'h0200_020c);
    avs_byteenable <= 4'h2;
    bus(1'b1, pefc_pkg::OFS_EVENT_SELECTION_REGISTER_BASE, 32'hffff_0000);
    avs_byteenable <= 4'hf;
    rdc("escr0 lanes", pefc_pkg::OFS_EVENT_SELECTION_REGISTER_BASE, 32'h0200_000c);
    foreach (modes[m]) begin
      // A complemented compare passes a zero input, so its idle level is all ones.
      quiet = (modes[m].compare && modes[m].complement) ? 4'hf : 4'h0;
      src_u.drive(quiet);
      bus(1'b1, pefc_pkg::OFS_CNT0_LO, 32'h0);
      bus(1'b1, pefc_pkg::OFS_CCCR0, counter_configuration_register(1'b1, 3'h0, modes[m], 1'b0));
      play(quiet);
      bus(1'b1, pefc_pkg::OFS_CCCR0, counter_configuration_register(1'b0, 3'h0, modes[m], 1'b0));
      play(quiet);
      rdc("count", pefc_pkg::OFS_CNT0_LO, expect_cnt(modes[m]));
    end
    src_u.drive(4'h0);
    bus(1'b1, pefc_pkg::OFS_EVENT_SELECTION_REGISTER_BASE, 32'h0200_0208);
    for (int u = 1; u >= 0; u--) begin
      src_u.set_user(u[0]);
      bus(1'b1, pefc_pkg::OFS_CNT0_LO, 32'h0);
      bus(1'b1, pefc_pkg::OFS_CCCR0, counter_configuration_register(1'b1, 3'h0, 7'h00, 1'b0));
      play(4'h0);
      bus(1'b1, pefc_pkg::OFS_CCCR0, counter_configuration_register(1'b0, 3'h0, 7'h00, 1'b0));
      rdc("privilege", pefc_pkg::OFS_CNT0_LO, u[0] ? 32'h0 : expect_cnt(7'h00));
    end
    bus(1'b1, pefc_pkg::OFS_CNT0_HI, 32'h0000_00ff);
    bus(1'b1, pefc_pkg::OFS_CNT0_LO, 32'hffff_fffe);
    bus(1'b1, pefc_pkg::OFS_CNT1_LO, 32'h0);
    bus(1'b1, pefc_pkg::OFS_CCCR1, counter_configuration_register(1'b0, 3'h1, 7'h00, 1'b1));
    bus(1'b1, pefc_pkg::OFS_CCCR0, counter_configuration_register(1'b1, 3'h0, 7'h00, 1'b0));
    src_u.drive(4'h1);
    src_u.drive(4'h1);
    src_u.drive(4'h0);
    repeat (4) @(posedge sys_clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    rdc("cccr0 ovf", pefc_pkg::OFS_CCCR0, counter_configuration_register(1'b1, 3'h0, 7'h00, 1'b0) | 32'h8000_0000);
    rdc("status", pefc_pkg::OFS_IRQ_STATUS, 32'h1);
    rdc("wrap hi", pefc_pkg::OFS_CNT0_HI, 32'h0);
    rdc("wrap lo", pefc_pkg::OFS_CNT0_LO, 32'h0);
    repeat (4) src_u.drive(4'h3);
    src_u.drive(4'h0);
    repeat (4) @(posedge sys_clk);
    rdc("cascade", pefc_pkg::OFS_CNT1_LO, 32'hc);
    rdc("after wrap", pefc_pkg::OFS_CNT0_LO, 32'hc);
    bus(1'b1, pefc_pkg::OFS_IRQ_MASK, 32'h1);
    repeat (3) @(posedge sys_clk);
    check("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, pefc_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge sys_clk);
    check("irq mask", {31'h0, irq}, 32'h0);
    bus(1'b1, pefc_pkg::OFS_IRQ_MASK, 32'h1);
    bus(1'b1, pefc_pkg::OFS_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge sys_clk);
    check("irq clear", {31'h0, irq}, 32'h0);
    bus(1'b1, pefc_pkg::OFS_CCCR0, counter_configuration_register(1'b0, 3'h0, 7'h00, 1'b0));
    play(4'h0);
    rdc("cascade stop", pefc_pkg::OFS_CNT1_LO, 32'hc);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end
endmodule : pefc_top_bench

bind pefc_top pefc_top_asserts chk_u (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq);
